// >>> rtl/csm_pkg.sv
// package: register map, field layout and types of the comparator status and mask select block
package csm_pkg;
  localparam int unsigned NUM_CMP          = 4;
  localparam logic [11:0] ADDR_STATUS      = 12'h000;
  localparam logic [11:0] ADDR_MASK_SRC    = 12'h004;
  localparam logic [11:0] ADDR_CMP_CTRL0   = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h018;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h01C;
  localparam int unsigned CTRL_STRIDE      = 4;
  localparam int unsigned POS_STOP_IDLE    = 15;
  localparam int unsigned POS_EVENT_LO     = 8;
  localparam int unsigned POS_OUTPUT_LO    = 0;
  localparam int unsigned POS_CTRL_EVENT   = 9;
  localparam int unsigned POS_CTRL_OUTPUT  = 8;
  localparam int unsigned POS_CTRL_POL     = 4;
  localparam int unsigned POS_CTRL_ENABLE  = 15;
  localparam logic [15:0] RST_CTRL         = 16'h0000;
  localparam logic [3:0]  RST_MASK_SRC     = 4'h0;
  localparam logic [3:0]  SRC_PWM_LAST     = 4'h5;
  localparam logic [3:0]  SRC_TRIG18       = 4'hC;
  localparam logic [3:0]  SRC_TRIG19       = 4'hD;
  localparam logic [3:0]  SRC_FAULT2       = 4'hE;
  localparam logic [3:0]  SRC_FAULT4       = 4'hF;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } csm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } csm_apb_rsp_t;

  typedef struct packed {
    logic [5:0] pwm;
    logic       trigger_out_18;
    logic       trigger_out_19;
    logic       fault_input_2;
    logic       fault_input_4;
  } csm_blank_src_t;
endpackage : csm_pkg

// >>> rtl/csm_top.sv
// comparator shared status, local control, mask-A source select and interrupt logic
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
//==========================================================================
// Summary of operation
// - stop-in-idle halts all comparators during idle
// - one event status bit per comparator
// - event bits mirror control bit nine
// - output bits mirror control bit eight
// - polarity bit inverts the output sense
// - mask A code picks blanking source
// - unimplemented status bits read zero
module csm_top #(
  parameter int unsigned NUM_CMP = csm_pkg::NUM_CMP
) (
  input  wire logic                    clk,          // 25 MHz peripheral clock
  input  wire logic                    rst_n,        // async reset, active low
  input  wire csm_pkg::csm_apb_req_t   apb_req,      // apb request
  output csm_pkg::csm_apb_rsp_t        apb_rsp,      // apb response
  input  wire logic                    idle_mode,    // device in idle
  input  wire logic [NUM_CMP-1:0]      cmp_raw,      // analog compare, vin+ > vin-, async
  input  wire csm_pkg::csm_blank_src_t blank_src,    // blanking sources, async
  output logic [NUM_CMP-1:0]           cmp_run,      // comparator running
  output logic                         mask_a_blank, // selected blanking input
  output logic                         irq           // level interrupt
);
  initial begin
    if (NUM_CMP != 4) $error("csm_top supports exactly four comparators");
  end

  //========================================================================
  // reset release
  logic rst_s1_ff;
  logic rst_s2_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_sync_n = rst_s2_ff;

  //========================================================================
  // input synchronisers: three stages, change taken when stages two and three agree
  localparam int unsigned SW = NUM_CMP + 10;
  wire  [SW-1:0] async_in = {blank_src, cmp_raw};
  logic [SW-1:0] sy1_ff;
  logic [SW-1:0] sy2_ff;
  logic [SW-1:0] sy3_ff;
  logic [SW-1:0] clean_ff;
  wire  [SW-1:0] agree = ~(sy2_ff ^ sy3_ff);
  wire  [SW-1:0] nxt_clean = (agree & sy3_ff) | (~agree & clean_ff);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sy1_ff   <= '0;
      sy2_ff   <= '0;
      sy3_ff   <= '0;
      clean_ff <= '0;
    end else begin
      sy1_ff   <= async_in;
      sy2_ff   <= sy1_ff;
      sy3_ff   <= sy2_ff;
      clean_ff <= nxt_clean;
    end
  end
  wire [NUM_CMP-1:0]       cmp_clean = clean_ff[NUM_CMP-1:0];
  csm_pkg::csm_blank_src_t src_clean;
  assign src_clean = clean_ff[SW-1:NUM_CMP];

  //========================================================================
  // apb decode
  wire acc      = apb_req.psel & apb_req.penable;
  wire wr       = acc & apb_req.pwrite;
  wire sel_stat = apb_req.paddr == csm_pkg::ADDR_STATUS;
  wire sel_msk  = apb_req.paddr == csm_pkg::ADDR_MASK_SRC;
  wire sel_ist  = apb_req.paddr == csm_pkg::ADDR_IRQ_STATUS;
  wire sel_imk  = apb_req.paddr == csm_pkg::ADDR_IRQ_MASK;
  wire [NUM_CMP-1:0] sel_ctl;
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_dec
    assign sel_ctl[i] = apb_req.paddr ==
      12'(csm_pkg::ADDR_CMP_CTRL0 + 12'(i * csm_pkg::CTRL_STRIDE));
  end
  wire mapped = sel_stat | sel_msk | sel_ist | sel_imk | (|sel_ctl);

  //========================================================================
  // shared status control and mask select
  logic       stop_idle_ff;
  logic [3:0] mask_a_source_ff;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stop_idle_ff     <= 1'b0;
      mask_a_source_ff <= csm_pkg::RST_MASK_SRC;
    end else begin
      if (wr && sel_stat) begin
        stop_idle_ff <= apb_req.pwdata[csm_pkg::POS_STOP_IDLE];
      end
      if (wr && sel_msk) begin
        mask_a_source_ff <= apb_req.pwdata[3:0];
      end
    end
  end

  //========================================================================
  // per-comparator control: enable, polarity, event, output
  logic [NUM_CMP-1:0] en_ff;
  logic [NUM_CMP-1:0] pol_ff;
  logic [NUM_CMP-1:0] evt_ff;
  logic [NUM_CMP-1:0] out_ff;
  assign cmp_run = en_ff & ~{NUM_CMP{stop_idle_ff & idle_mode}};
  wire [NUM_CMP-1:0] nxt_out = cmp_run & (cmp_clean ^ pol_ff);
  // an event is any change of a running comparator's output
  wire [NUM_CMP-1:0] evt_hit = cmp_run & (nxt_out ^ out_ff);
  wire [NUM_CMP-1:0] evt_clr;
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_clr
    assign evt_clr[i] = wr & sel_ctl[i] & ~apb_req.pwdata[csm_pkg::POS_CTRL_EVENT];
  end
  wire [NUM_CMP-1:0] nxt_evt = evt_hit | (evt_ff & ~evt_clr);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      en_ff  <= '0;
      pol_ff <= '0;
      evt_ff <= '0;
      out_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (wr && sel_ctl[i]) begin
          en_ff[i]  <= apb_req.pwdata[csm_pkg::POS_CTRL_ENABLE];
          pol_ff[i] <= apb_req.pwdata[csm_pkg::POS_CTRL_POL];
        end
      end
      // event set wins over a clear in the same cycle
      evt_ff <= nxt_evt;
      out_ff <= nxt_out;
    end
  end

  //========================================================================
  // mask A blanking source
  // source selection
  assign mask_a_blank =
    (mask_a_source_ff <= csm_pkg::SRC_PWM_LAST) ? src_clean.pwm[mask_a_source_ff[2:0]] :
    (mask_a_source_ff == csm_pkg::SRC_TRIG18)   ? src_clean.trigger_out_18 :
    (mask_a_source_ff == csm_pkg::SRC_TRIG19)   ? src_clean.trigger_out_19 :
    (mask_a_source_ff == csm_pkg::SRC_FAULT2)   ? src_clean.fault_input_2 :
    (mask_a_source_ff == csm_pkg::SRC_FAULT4)   ? src_clean.fault_input_4 : 1'b0;

  //========================================================================
  // interrupts: event rise sets sticky bit, write one clears
  logic [NUM_CMP-1:0] irq_stat_ff;
  logic [NUM_CMP-1:0] irq_mask_ff;
  wire  [NUM_CMP-1:0] irq_w1c = {NUM_CMP{wr & sel_ist}} & apb_req.pwdata[NUM_CMP-1:0];
  wire  [NUM_CMP-1:0] nxt_irq_stat = (nxt_evt & ~evt_ff) | (irq_stat_ff & ~irq_w1c);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr && sel_imk) begin
        irq_mask_ff <= apb_req.pwdata[NUM_CMP-1:0];
      end
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  //========================================================================
  // read mux
  // event bits in status
  wire [15:0] status_word = 16'({stop_idle_ff, 15'h0000}) |
                            16'({evt_ff, 8'h00}) | 16'(out_ff);
  logic [15:0] ctl_word;
  always_comb begin
    ctl_word = 16'h0000;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (sel_ctl[i]) begin
        ctl_word = 16'({en_ff[i], 5'h00, evt_ff[i], out_ff[i], 3'h0, pol_ff[i], 4'h0});
      end
    end
  end
  wire [31:0] rd_word =
    sel_stat ? {16'h0000, status_word} :
    sel_msk  ? {28'h0000000, mask_a_source_ff} :
    sel_ist  ? {28'h0000000, irq_stat_ff} :
    sel_imk  ? {28'h0000000, irq_mask_ff} : {16'h0000, ctl_word};

  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= (apb_req.psel && !apb_req.penable && !apb_req.pwrite && mapped) ?
                    rd_word : 32'h00000000;
      pslverr_ff <= apb_req.psel & ~apb_req.penable & ~mapped;
    end
  end
  assign apb_rsp.prdata  = prdata_ff;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = pslverr_ff & acc;

  //========================================================================
  // checks
  a_idle_halt: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (stop_idle_ff && idle_mode) |-> cmp_run == '0)
    else $error("comparators run while stopped in idle");
  a_idle_keep: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!stop_idle_ff || !idle_mode) |-> cmp_run == en_ff)
    else $error("comparators halted outside stop-in-idle");
  a_evt_sticky: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (evt_ff[0] && !evt_clr[0]) |=> evt_ff[0])
    else $error("event flag lost without a clear");
  a_evt_mirror: assert property (@(posedge clk) disable iff (!rst_sync_n)
    status_word[11:8] == evt_ff)
    else $error("status event bits differ from control event bits");
  a_out_mirror: assert property (@(posedge clk) disable iff (!rst_sync_n)
    status_word[3:0] == out_ff)
    else $error("status output bits differ from control output bits");
  a_pol_sense: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cmp_run[0] |=> out_ff[0] == ($past(cmp_clean[0]) ^ $past(pol_ff[0])))
    else $error("output sense does not follow polarity");
  a_src_fault4: assert property (@(posedge clk) disable iff (!rst_sync_n)
    mask_a_source_ff == csm_pkg::SRC_FAULT4 |-> mask_a_blank == src_clean.fault_input_4)
    else $error("code 1111 does not select fault 4");
  a_src_reserved: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (mask_a_source_ff > csm_pkg::SRC_PWM_LAST && mask_a_source_ff < csm_pkg::SRC_TRIG18)
      |-> !mask_a_blank)
    else $error("reserved mask code drives blanking");
  a_unused_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
    status_word[14:12] == 3'h0 && status_word[7:4] == 4'h0)
    else $error("unimplemented status bits not zero");
  a_stat_nowrite: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (wr && sel_stat && !evt_hit[0]) |=> evt_ff[0] == $past(evt_ff[0]))
    else $error("status write changed an event flag");

  //========================================================================
  // sequential checks: the register checks look one edge ahead, so a broken register shows up; the source select and upper data checks look at the same edge

  a_evt_set: assert property (@(posedge clk) disable iff (!rst_sync_n)
    evt_hit[1] |=> evt_ff[1])
    else $error("event did not set its flag");

  a_evt_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (evt_clr[2] && !evt_hit[2]) |=> !evt_ff[2])
    else $error("event flag not cleared by control write");

  a_evt_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!evt_hit[3] && !evt_clr[3]) |=> evt_ff[3] == $past(evt_ff[3]))
    else $error("event flag changed without event or clear");

  a_stop_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (wr && sel_stat) |=> stop_idle_ff == $past(apb_req.pwdata[15]))
    else $error("stop-in-idle bit not taken from write");

  a_stop_keep: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !(wr && sel_stat) |=> stop_idle_ff == $past(stop_idle_ff))
    else $error("stop-in-idle bit changed without write");

  a_out_halt: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !cmp_run[3] |=> !out_ff[3])
    else $error("halted comparator output not low");

  a_pol_inv: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cmp_run[1] |=> out_ff[1] == ($past(cmp_clean[1]) ^ $past(pol_ff[1])))
    else $error("second comparator sense does not follow polarity");

  a_src_pwm0: assert property (@(posedge clk) disable iff (!rst_sync_n)
    mask_a_source_ff == 4'h0 |-> mask_a_blank == src_clean.pwm[0])
    else $error("code 0000 does not select first pwm low");

  a_src_pwm3: assert property (@(posedge clk) disable iff (!rst_sync_n)
    mask_a_source_ff == 4'h3 |-> mask_a_blank == src_clean.pwm[3])
    else $error("code 0011 does not select second pwm high");

  a_src_pwm5: assert property (@(posedge clk) disable iff (!rst_sync_n)
    mask_a_source_ff == 4'h5 |-> mask_a_blank == src_clean.pwm[5])
    else $error("code 0101 does not select third pwm high");

  a_src_trig18: assert property (@(posedge clk) disable iff (!rst_sync_n)
    mask_a_source_ff == 4'hC |-> mask_a_blank == src_clean.trigger_out_18)
    else $error("code 1100 does not select trigger 18");

  a_src_trig19: assert property (@(posedge clk) disable iff (!rst_sync_n)
    mask_a_source_ff == 4'hD |-> mask_a_blank == src_clean.trigger_out_19)
    else $error("code 1101 does not select trigger 19");

  a_src_fault2: assert property (@(posedge clk) disable iff (!rst_sync_n)
    mask_a_source_ff == 4'hE |-> mask_a_blank == src_clean.fault_input_2)
    else $error("code 1110 does not select fault 2");

  a_mask_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (wr && sel_msk) |=> mask_a_source_ff == $past(apb_req.pwdata[3:0]))
    else $error("mask source not taken from write");

  a_stat_read: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (apb_req.psel && !apb_req.penable && !apb_req.pwrite && sel_stat)
      |=> apb_rsp.prdata[11:8] == $past(evt_ff))
    else $error("status read does not return event flags");

  a_upper_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
    apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");

  // event rise sets interrupt
  a_irq_set: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (nxt_evt[0] && !evt_ff[0]) |=> irq_stat_ff[0])
    else $error("event rise did not set interrupt status");

  // write one clears interrupt
  a_irq_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (irq_w1c[1] && !(nxt_evt[1] && !evt_ff[1])) |=> !irq_stat_ff[1])
    else $error("interrupt status not cleared by write one");

  // unmapped address flags error
  a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (apb_req.psel && !apb_req.penable && !mapped) ##1 (apb_req.psel && apb_req.penable) |-> apb_rsp.pslverr)
    else $error("unmapped access without error response");

  // mapped address no error
  a_mapped_ok: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (apb_req.psel && !apb_req.penable && mapped) |=> !apb_rsp.pslverr)
    else $error("mapped access flagged an error");
endmodule // csm_top

// >>> sim/comparator_status_mask_select_bench.sv
// self-checking bench for the comparator status, mask select and interrupt block
`timescale 1ns/100ps
module comparator_status_mask_select_bench;
  logic                  clk;
  logic                  rst_n;
  csm_pkg::csm_apb_req_t apb_req;
  csm_pkg::csm_apb_rsp_t apb_rsp;
  logic                  idle_mode;
  logic [3:0]            cmp_raw;
  logic [9:0]            src_v;
  logic [3:0]            cmp_run;
  logic                  mask_a_blank;
  logic                  irq;
  logic [31:0]           rd;
  logic                  err;
  int                    err_total;
  int                    n_compared;
  int                    idx;

  csm_top dut (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .idle_mode(idle_mode),
    .cmp_raw(cmp_raw), .blank_src(csm_pkg::csm_blank_src_t'(src_v)), .cmp_run(cmp_run),
    .mask_a_blank(mask_a_blank), .irq(irq));

  //==========================================================================
  // shared tasks
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  // apb transfer; answer taken at the rising edge that samples pready high, released right after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n >= 20 && apb_rsp.pready !== 1'b1) begin
      err_total++;
      stop_test();
    end
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  function automatic int src_idx(input logic [3:0] c);
    if (c <= csm_pkg::SRC_PWM_LAST) return 4 + int'(c);
    if (c == csm_pkg::SRC_TRIG18) return 3;
    if (c == csm_pkg::SRC_TRIG19) return 2;
    if (c == csm_pkg::SRC_FAULT2) return 1;
    if (c == csm_pkg::SRC_FAULT4) return 0;
    return -1;
  endfunction

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  //==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    apb_req = '0;
    idle_mode = 1'b0;
    cmp_raw = 4'h0;
    src_v = 10'h000;
    err_total = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(12'h000, 32'h0000_0000);
    rdc(12'h004, 32'h0000_0000);
    wr(12'h000, 32'hFFFF_FFFF);
    rdc(12'h000, 32'h0000_8000);
    wr(12'h000, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[31:1], err}, 32'h0000_0001);
    $display("test registers done");
    // enable all with inputs low: outputs stay low, so no event yet
    for (int i = 0; i < 4; i++) wr(12'h008 + 12'(4 * i), 32'h0000_8000);
    @(negedge clk);
    chk({28'h0, cmp_run}, 32'h0000_000F);
    rdc(12'h000, 32'h0000_0000);
    cmp_raw <= 4'h5;
    repeat (10) @(posedge clk);
    rdc(12'h000, 32'h0000_0505);
    rdc(12'h008, 32'h0000_8300);
    // bit nine written as one so the polarity write cannot clear the event
    wr(12'h014, 32'h0000_8210);
    repeat (10) @(posedge clk);
    rdc(12'h000, 32'h0000_0D0D);
    for (int i = 0; i < 3; i++) wr(12'h008 + 12'(4 * i), 32'h0000_8000);
    wr(12'h014, 32'h0000_8010);
    rdc(12'h000, 32'h0000_000D);
    wr(12'h000, 32'h0000_0F0F);
    rdc(12'h000, 32'h0000_000D);
    $display("test status mirrors done");
    rdc(12'h018, 32'h0000_000D);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(12'h01C, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(12'h018, 32'h0000_000F);
    rdc(12'h018, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test interrupt done");
    for (int c = 0; c < 16; c++) begin
      wr(12'h004, 32'(c));
      rdc(12'h004, 32'(c));
      idx = src_idx(4'(c));
      if (idx >= 0) begin
        src_v <= 10'h001 << idx;
        repeat (6) @(posedge clk);
        chk({31'h0, mask_a_blank}, 32'h0000_0001);
        src_v <= ~(10'h001 << idx);
        repeat (6) @(posedge clk);
        chk({31'h0, mask_a_blank}, 32'h0000_0000);
      end else begin
        src_v <= 10'h3FF;
        repeat (6) @(posedge clk);
        chk({31'h0, mask_a_blank}, 32'h0000_0000);
      end
    end
    $display("test mask select done");
    wr(12'h000, 32'h0000_8000);
    idle_mode <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({28'h0, cmp_run}, 32'h0000_0000);
    wr(12'h000, 32'h0000_0000);
    @(negedge clk);
    chk({28'h0, cmp_run}, 32'h0000_000F);
    idle_mode <= 1'b0;
    $display("test stop in idle done");
    stop_test();
  end
endmodule // comparator_status_mask_select_bench
